/* File: shared/phyreg_defs.vh */
`ifndef PHYREG_DEFS_VH
`define PHYREG_DEFS_VH

// ****************************************
// location offsets
// ****************************************
`define PHYREG_A_MODE        6'h00
`define PHYREG_A_CONFIG      6'h01
`define PHYREG_A_INT_COND    6'h02
`define PHYREG_A_INT_MASK    6'h03
`define PHYREG_A_TX_STATE    6'h04
`define PHYREG_A_INJ_THR     6'h05
`define PHYREG_A_INJ_SYM_A   6'h06
`define PHYREG_A_INJ_SYM_B   6'h07
`define PHYREG_A_RX_STATE    6'h08
`define PHYREG_A_RX_COND_A   6'h09
`define PHYREG_A_RX_COND_B   6'h0a
`define PHYREG_A_RX_MASK_A   6'h0b
`define PHYREG_A_RX_MASK_B   6'h0c
`define PHYREG_A_NOISE_THR   6'h0d
`define PHYREG_A_NOISE_PTHR  6'h0e
`define PHYREG_A_NOISE_CNT   6'h0f
`define PHYREG_A_NOISE_PCNT  6'h10
`define PHYREG_A_STATE_THR   6'h11
`define PHYREG_A_STATE_PTHR  6'h12
`define PHYREG_A_STATE_CNT   6'h13
`define PHYREG_A_STATE_PCNT  6'h14
`define PHYREG_A_LERR_THR    6'h15
`define PHYREG_A_LERR_CNT    6'h16
`define PHYREG_A_USER        6'h17
`define PHYREG_A_IDENT       6'h18
`define PHYREG_A_INJ_CNT     6'h19
`define PHYREG_A_INT_CMP     6'h1a
`define PHYREG_A_TX_CMP      6'h1b
`define PHYREG_A_RX_CMP_A    6'h1c
`define PHYREG_A_RX_CMP_B    6'h1d
`define PHYREG_A_MODE_TWO    6'h1e
`define PHYREG_A_CONN_CMP    6'h1f
`define PHYREG_A_CONN_COND   6'h20
`define PHYREG_A_CONN_MASK   6'h21
`define PHYREG_A_RSVD_LO     6'h22
`define PHYREG_A_RSVD_HI     6'h23
`define PHYREG_A_SCRUB_THR   6'h24
`define PHYREG_A_SCRUB_VAL   6'h25
`define PHYREG_A_TRIG_DEF    6'h26
`define PHYREG_A_TRIG_CFG    6'h27
`define PHYREG_A_RSVD2_LO    6'h28
`define PHYREG_A_RSVD2_HI    6'h3a
`define PHYREG_A_CLK_GEN     6'h3b
`define PHYREG_A_ALT_MEDIA   6'h3c
`define PHYREG_A_GAIN        6'h3d

// ****************************************
// access classes
// ****************************************
`define PHYREG_CL_RW         2'h0
`define PHYREG_CL_COND       2'h1
`define PHYREG_CL_RO         2'h2
`define PHYREG_CL_RSVD       2'h3

// ****************************************
// reset values
// ****************************************
`define PHYREG_RST_ZERO      8'h00
`define PHYREG_RST_INT_COND  8'h10
`define PHYREG_RST_TX_STATE  8'ha2
`define PHYREG_RST_RX_COND_A 8'h20
`define PHYREG_RST_RX_COND_B 8'h02
`define PHYREG_RSVD_READ     8'h00

`endif

/* File: hw/phyreg_cell.v */
`include "phyreg_defs.vh"

// one eight-bit location: host write plus hardware set bits
module phyreg_cell #(
    parameter [7:0] RST_VAL = `PHYREG_RST_ZERO
) (
    // clock and reset
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire       ce,
    // host write
    input  wire       wr_en,
    input  wire [7:0] wdata,
    // hardware event bits
    input  wire [7:0] set,
    // contents
    output wire [7:0] q
);

    reg  [7:0] val_q;
    wire [7:0] val_d;

    // set wins over a host write in the same cycle
    assign val_d = (wr_en ? wdata : val_q) | set;
    assign q     = val_q;

    // storage, frozen while ce is low
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            val_q <= RST_VAL;
        end
        else if (ce)
        begin
            val_q <= val_d;
        end
    end

endmodule // phyreg_cell

/* File: hw/phyreg_bank.v */
`include "phyreg_defs.vh"

module phyreg_bank #(
    // arbitrary neutral identity value
    parameter [7:0] DEVICE_ID = 8'h5a
) (
    // clock, reset, enable
    input  wire       ref_clk,
    input  wire       rst_b,
    input  wire       ce,
    // control bus
    input  wire       cb_sel,
    input  wire       cb_wr,
    input  wire [5:0] cb_addr,
    input  wire [7:0] cb_wdata,
    output reg  [7:0] cb_rdata,
    output reg        cb_ack,
    // conditional write permissions
    input  wire       wr_allow_config,
    input  wire       wr_allow_int_cond,
    input  wire       wr_allow_tx_state,
    input  wire       wr_allow_rx_cond_a,
    input  wire       wr_allow_rx_cond_b,
    input  wire       wr_allow_mode_two,
    input  wire       wr_allow_conn_cond,
    // hardware event set bits
    input  wire [7:0] int_cond_set,
    input  wire [7:0] rx_cond_a_set,
    input  wire [7:0] rx_cond_b_set,
    input  wire [7:0] conn_cond_set,
    // live state shown read-only
    input  wire [7:0] rx_state_cur,
    input  wire [7:0] noise_cnt_cur,
    input  wire [7:0] noise_pcnt_cur,
    input  wire [7:0] state_cnt_cur,
    input  wire [7:0] state_pcnt_cur,
    input  wire [7:0] link_err_cnt_cur,
    input  wire [7:0] inj_cnt_cur,
    input  wire [7:0] scrub_val_cur,
    // stored contents toward the device
    output wire [7:0] mode_control,
    output wire [7:0] configuration_select,
    output wire [7:0] interrupt_condition,
    output wire [7:0] interrupt_condition_mask,
    output wire [7:0] transmit_state_current,
    output wire [7:0] injection_threshold,
    output wire [7:0] injection_symbol_a,
    output wire [7:0] injection_symbol_b,
    output wire [7:0] receive_condition_a,
    output wire [7:0] receive_condition_b,
    output wire [7:0] receive_condition_mask_a,
    output wire [7:0] receive_condition_mask_b,
    output wire [7:0] noise_threshold,
    output wire [7:0] noise_prescale_threshold,
    output wire [7:0] state_threshold,
    output wire [7:0] state_prescale_threshold,
    output wire [7:0] link_error_threshold,
    output wire [7:0] user_definable,
    output wire [7:0] interrupt_condition_compare,
    output wire [7:0] transmit_state_compare,
    output wire [7:0] receive_condition_compare_a,
    output wire [7:0] receive_condition_compare_b,
    output wire [7:0] second_mode_control,
    output wire [7:0] connection_mgmt_compare,
    output wire [7:0] connection_mgmt_condition,
    output wire [7:0] connection_mgmt_mask,
    output wire [7:0] scrub_timer_threshold,
    output wire [7:0] trigger_definition,
    output wire [7:0] trigger_transition_config,
    output wire [7:0] clock_generation_control,
    output wire [7:0] alternate_media_control,
    output wire [7:0] recovery_gain_control
);

    // ****************************************
    // access class and reset lookup
    // ****************************************

    function [1:0] loc_class;
        input [5:0] a;
        begin
            case (a)
                // written only when the device allows it
                `PHYREG_A_CONFIG,
                `PHYREG_A_INT_COND,
                `PHYREG_A_TX_STATE,
                `PHYREG_A_RX_COND_A,
                `PHYREG_A_RX_COND_B,
                `PHYREG_A_MODE_TWO,
                `PHYREG_A_CONN_COND:
                    loc_class = `PHYREG_CL_COND;
                // live values, nothing stored behind them
                `PHYREG_A_RX_STATE,
                `PHYREG_A_NOISE_CNT,
                `PHYREG_A_NOISE_PCNT,
                `PHYREG_A_STATE_CNT,
                `PHYREG_A_STATE_PCNT,
                `PHYREG_A_LERR_CNT,
                `PHYREG_A_IDENT,
                `PHYREG_A_INJ_CNT,
                `PHYREG_A_SCRUB_VAL:
                    loc_class = `PHYREG_CL_RO;
                // reserved gaps, plain storage everywhere else
                default:
                begin
                    if ((a >= `PHYREG_A_RSVD_LO && a <= `PHYREG_A_RSVD_HI) ||
                        (a >= `PHYREG_A_RSVD2_LO && a <= `PHYREG_A_RSVD2_HI) ||
                        (a > `PHYREG_A_GAIN))
                    begin
                        loc_class = `PHYREG_CL_RSVD;
                    end
                    else
                    begin
                        loc_class = `PHYREG_CL_RW;
                    end
                end
            endcase
        end
    endfunction

    function [7:0] loc_reset;
        input [5:0] a;
        begin
            case (a)
                `PHYREG_A_INT_COND:  loc_reset = `PHYREG_RST_INT_COND;
                `PHYREG_A_TX_STATE:  loc_reset = `PHYREG_RST_TX_STATE;
                `PHYREG_A_RX_COND_A: loc_reset = `PHYREG_RST_RX_COND_A;
                `PHYREG_A_RX_COND_B: loc_reset = `PHYREG_RST_RX_COND_B;
                default:             loc_reset = `PHYREG_RST_ZERO;
            endcase
        end
    endfunction

    // ****************************************
    // reset release
    // ****************************************

    reg  rst_sync1_q;
    reg  rst_sync2_q;
    wire rst_n;

    // two flops so release never lands near an edge
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_sync1_q <= 1'b0;
            rst_sync2_q <= 1'b0;
        end
        else
        begin
            rst_sync1_q <= 1'b1;
            rst_sync2_q <= rst_sync1_q;
        end
    end

    assign rst_n = rst_sync2_q;

    // ****************************************
    // write decode
    // ****************************************

    wire        wr_req;
    reg  [63:0] wr_allow_vec;
    integer     k;

    assign wr_req = cb_sel & cb_wr & ce;

    // per-location permission for the current cycle
    always @*
    begin
        wr_allow_vec = 64'h0;
        for (k = 0; k < 64; k = k + 1)
        begin
            if (loc_class(k[5:0]) == `PHYREG_CL_RW)
                wr_allow_vec[k] = 1'b1;
        end
        wr_allow_vec[`PHYREG_A_CONFIG]    = wr_allow_config;
        wr_allow_vec[`PHYREG_A_INT_COND]  = wr_allow_int_cond;
        wr_allow_vec[`PHYREG_A_TX_STATE]  = wr_allow_tx_state;
        wr_allow_vec[`PHYREG_A_RX_COND_A] = wr_allow_rx_cond_a;
        wr_allow_vec[`PHYREG_A_RX_COND_B] = wr_allow_rx_cond_b;
        wr_allow_vec[`PHYREG_A_MODE_TWO]  = wr_allow_mode_two;
        wr_allow_vec[`PHYREG_A_CONN_COND] = wr_allow_conn_cond;
    end

    // ****************************************
    // storage locations
    // ****************************************

    wire [7:0] cell_q [0:63];

    genvar i;
    generate
        for (i = 0; i < 64; i = i + 1)
        begin : g_loc
            // location index cut to the bus width on purpose
            localparam integer LOC_I = i;
            localparam [5:0]   LOC   = LOC_I[5:0];
            if (loc_class(LOC) == `PHYREG_CL_RW || loc_class(LOC) == `PHYREG_CL_COND)
            begin : g_store
                wire [7:0] set_bits;
                // only the condition locations collect events
                assign set_bits =
                    (LOC == `PHYREG_A_INT_COND)  ? int_cond_set  :
                    (LOC == `PHYREG_A_RX_COND_A) ? rx_cond_a_set :
                    (LOC == `PHYREG_A_RX_COND_B) ? rx_cond_b_set :
                    (LOC == `PHYREG_A_CONN_COND) ? conn_cond_set : 8'h00;
                phyreg_cell #(
                    .RST_VAL (loc_reset(LOC))
                ) u_cell (
                    .ref_clk (ref_clk),
                    .rst_n   (rst_n),
                    .ce      (ce),
                    .wr_en   (wr_req & (cb_addr == LOC) & wr_allow_vec[i]),
                    .wdata   (cb_wdata),
                    .set     (set_bits),
                    .q       (cell_q[i])
                );
            end
            else
            begin : g_none
                // no storage, so a write has nothing to change
                assign cell_q[i] = 8'h00;
            end
        end
    endgenerate

    // ****************************************
    // read mux
    // ****************************************

    reg [7:0] rd_mux;

    // live values for read-only locations, stored bytes otherwise
    always @*
    begin
        case (cb_addr)
            `PHYREG_A_RX_STATE:   rd_mux = rx_state_cur;
            `PHYREG_A_NOISE_CNT:  rd_mux = noise_cnt_cur;
            `PHYREG_A_NOISE_PCNT: rd_mux = noise_pcnt_cur;
            `PHYREG_A_STATE_CNT:  rd_mux = state_cnt_cur;
            `PHYREG_A_STATE_PCNT: rd_mux = state_pcnt_cur;
            `PHYREG_A_LERR_CNT:   rd_mux = link_err_cnt_cur;
            `PHYREG_A_IDENT:      rd_mux = DEVICE_ID;
            `PHYREG_A_INJ_CNT:    rd_mux = inj_cnt_cur;
            `PHYREG_A_SCRUB_VAL:  rd_mux = scrub_val_cur;
            default:
            begin
                // reserved reads answer with a fixed byte
                if (loc_class(cb_addr) == `PHYREG_CL_RSVD)
                begin
                    rd_mux = `PHYREG_RSVD_READ;
                end
                else
                begin
                    rd_mux = cell_q[cb_addr];
                end
            end
        endcase
    end

    // ****************************************
    // bus answer
    // ****************************************

    // every access is acknowledged, rejected writes included
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cb_ack   <= 1'b0;
            cb_rdata <= 8'h00;
        end
        else if (ce)
        begin
            // a request met while ce is low is not taken at all
            cb_ack <= cb_sel;
            // data captured only on reads so it stays put between them
            if (cb_sel && !cb_wr)
            begin
                cb_rdata <= rd_mux;
            end
        end
    end

    // ****************************************
    // contents toward the device
    // ****************************************

    // reserved writes are simply dropped, the host must not rely on it
    // mode, configuration and interrupt set-up
    assign mode_control                = cell_q[`PHYREG_A_MODE];
    assign configuration_select        = cell_q[`PHYREG_A_CONFIG];
    assign interrupt_condition         = cell_q[`PHYREG_A_INT_COND];
    assign interrupt_condition_mask    = cell_q[`PHYREG_A_INT_MASK];

    // transmit state and symbol injection
    assign transmit_state_current      = cell_q[`PHYREG_A_TX_STATE];
    assign injection_threshold         = cell_q[`PHYREG_A_INJ_THR];
    assign injection_symbol_a          = cell_q[`PHYREG_A_INJ_SYM_A];
    assign injection_symbol_b          = cell_q[`PHYREG_A_INJ_SYM_B];

    // receive conditions and their masks
    assign receive_condition_a         = cell_q[`PHYREG_A_RX_COND_A];
    assign receive_condition_b         = cell_q[`PHYREG_A_RX_COND_B];
    assign receive_condition_mask_a    = cell_q[`PHYREG_A_RX_MASK_A];
    assign receive_condition_mask_b    = cell_q[`PHYREG_A_RX_MASK_B];

    // noise, state and link error thresholds, user byte
    assign noise_threshold             = cell_q[`PHYREG_A_NOISE_THR];
    assign noise_prescale_threshold    = cell_q[`PHYREG_A_NOISE_PTHR];
    assign state_threshold             = cell_q[`PHYREG_A_STATE_THR];
    assign state_prescale_threshold    = cell_q[`PHYREG_A_STATE_PTHR];
    assign link_error_threshold        = cell_q[`PHYREG_A_LERR_THR];
    assign user_definable              = cell_q[`PHYREG_A_USER];

    // comparison values
    assign interrupt_condition_compare = cell_q[`PHYREG_A_INT_CMP];
    assign transmit_state_compare      = cell_q[`PHYREG_A_TX_CMP];
    assign receive_condition_compare_a = cell_q[`PHYREG_A_RX_CMP_A];
    assign receive_condition_compare_b = cell_q[`PHYREG_A_RX_CMP_B];

    // second mode and connection management
    assign second_mode_control         = cell_q[`PHYREG_A_MODE_TWO];
    assign connection_mgmt_compare     = cell_q[`PHYREG_A_CONN_CMP];
    assign connection_mgmt_condition   = cell_q[`PHYREG_A_CONN_COND];
    assign connection_mgmt_mask        = cell_q[`PHYREG_A_CONN_MASK];

    // scrub, trigger, clocking and front end controls
    assign scrub_timer_threshold       = cell_q[`PHYREG_A_SCRUB_THR];
    assign trigger_definition          = cell_q[`PHYREG_A_TRIG_DEF];
    assign trigger_transition_config   = cell_q[`PHYREG_A_TRIG_CFG];
    assign clock_generation_control    = cell_q[`PHYREG_A_CLK_GEN];
    assign alternate_media_control     = cell_q[`PHYREG_A_ALT_MEDIA];
    assign recovery_gain_control       = cell_q[`PHYREG_A_GAIN];

endmodule // phyreg_bank

/* File: sim/phyreg_bank_props.sv */
// ****************************************
// control bus checks
// ****************************************
module phyreg_bank_props (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire logic       ce,
    // control bus
    input wire logic       cb_sel,
    input wire logic       cb_wr,
    input wire logic [5:0] cb_addr,
    input wire logic [7:0] cb_wdata,
    input wire logic [7:0] cb_rdata,
    input wire logic       cb_ack,
    // watched contents
    input wire logic       wr_allow_config,
    input wire logic [7:0] rx_state_cur,
    input wire logic [7:0] mode_control,
    input wire logic [7:0] configuration_select,
    input wire logic [7:0] recovery_gain_control
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    // one taken access, a write or a read to one place
    sequence s_take;
        ce && cb_sel;
    endsequence
    sequence s_wr(logic [5:0] a);
        s_take ##0 cb_wr && cb_addr == a;
    endsequence
    sequence s_rd(logic [5:0] a);
        s_take ##0 !cb_wr && cb_addr == a;
    endsequence

    a_ack_after_req: assert property (s_take |=> cb_ack)
        else $error("request without ack");
    a_no_idle_ack: assert property (ce && !cb_sel |=> !cb_ack)
        else $error("ack without request");
    a_rw_mode_take: assert property (s_wr(6'h00) |=> mode_control == $past(cb_wdata))
        else $error("mode write lost");
    a_rw_gain_take: assert property (s_wr(6'h3d) |=> recovery_gain_control == $past(cb_wdata))
        else $error("gain write lost");
    a_cond_take: assert property (s_wr(6'h01) ##0 wr_allow_config |=> configuration_select == $past(cb_wdata))
        else $error("permitted write lost");
    a_cond_block: assert property (s_wr(6'h01) ##0 !wr_allow_config |=> $stable(configuration_select))
        else $error("blocked write landed");
    a_ro_live_read: assert property (s_rd(6'h08) |=> cb_rdata == $past(rx_state_cur))
        else $error("live state misread");
    a_ro_no_effect: assert property (s_wr(6'h08) |=>
        $stable({mode_control, configuration_select, recovery_gain_control}))
        else $error("rejected write disturbed contents");
    a_rd_mode: assert property (s_rd(6'h00) |=> cb_rdata == $past(mode_control))
        else $error("mode misread");
    a_rsvd_read_ack: assert property (s_rd(6'h3f) |=> cb_ack)
        else $error("reserved read unanswered");
endmodule // phyreg_bank_props

/* File: sim/phyreg_host.sv */
// ****************************************
// host on the control bus
// ****************************************
module phyreg_host (
    // clock
    input  wire logic       ref_clk,
    // control bus requests
    output logic            cb_sel,
    output logic            cb_wr,
    output logic [5:0]      cb_addr,
    output logic [7:0]      cb_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // quiet bus at time zero
    initial
    begin
        cb_sel   = 1'b0;
        cb_wr    = 1'b0;
        cb_addr  = 6'h00;
        cb_wdata = 8'h00;
    end

    // reserved slots
    function automatic logic rsvd(input logic [5:0] a);
        return a == 6'h22 || a == 6'h23 || (a >= 6'h28 && a <= 6'h3a) || a >= 6'h3e;
    endfunction

    // bus access only
    // one access per call; calls back to back keep cb_sel high
    task automatic req(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        cb_wr    <= w && !rsvd(a);
        cb_sel   <= 1'b1;
        cb_addr  <= a;
        cb_wdata <= d;
    endtask

    // released lines flip so a stale value cannot pass
    task automatic idle;
        @(posedge ref_clk);
        cb_sel   <= 1'b0;
        cb_addr  <= ~cb_addr;
        cb_wdata <= ~cb_wdata;
    endtask
endmodule // phyreg_host

/* File: sim/phyreg_bank_tb.sv */
// ****************************************
// bench top
// ****************************************
module phyreg_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed { logic [5:0] a; logic chk; logic [7:0] v; } phyreg_note_t;
    // arbitrary identity value
    localparam logic [7:0] ID = 8'h3c;
    logic         ref_clk = 1'b0;
    logic         rst_b   = 1'b0;
    logic         ce      = 1'b1;
    logic [63:0]  alw     = '0;
    logic [7:0]   live [64];
    logic [7:0]   setv [64];
    logic [7:0]   exp_q [64];
    logic [5:0]   cl [7] = '{6'h01, 6'h02, 6'h04, 6'h09, 6'h0a, 6'h1e, 6'h20};
    logic [5:0]   el [4] = '{6'h02, 6'h09, 6'h0a, 6'h20};
    wire          cb_sel, cb_wr, cb_ack;
    wire  [5:0]   cb_addr;
    wire  [7:0]   cb_wdata, cb_rdata;
    wire  [7:0]   outv [64];
    phyreg_note_t notes [$];
    phyreg_note_t note;
    int           num_errors = 0;
    int           checked = 0;
    int           seed = 53;

    always #20 ref_clk = ~ref_clk;

    phyreg_host host (.ref_clk(ref_clk), .cb_sel(cb_sel), .cb_wr(cb_wr), .cb_addr(cb_addr), .cb_wdata(cb_wdata));

    phyreg_bank #(.DEVICE_ID(ID)) DUT (
        .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .cb_sel(cb_sel), .cb_wr(cb_wr), .cb_addr(cb_addr),
        .cb_wdata(cb_wdata), .cb_rdata(cb_rdata), .cb_ack(cb_ack),
        .wr_allow_config(alw[1]), .wr_allow_int_cond(alw[2]), .wr_allow_tx_state(alw[4]),
        .wr_allow_rx_cond_a(alw[9]), .wr_allow_rx_cond_b(alw[10]), .wr_allow_mode_two(alw[30]),
        .wr_allow_conn_cond(alw[32]), .int_cond_set(setv[2]), .rx_cond_a_set(setv[9]),
        .rx_cond_b_set(setv[10]), .conn_cond_set(setv[32]), .rx_state_cur(live[8]),
        .noise_cnt_cur(live[15]), .noise_pcnt_cur(live[16]), .state_cnt_cur(live[19]),
        .state_pcnt_cur(live[20]), .link_err_cnt_cur(live[22]), .inj_cnt_cur(live[25]),
        .scrub_val_cur(live[37]), .mode_control(outv[0]), .configuration_select(outv[1]),
        .interrupt_condition(outv[2]), .interrupt_condition_mask(outv[3]), .transmit_state_current(outv[4]),
        .injection_threshold(outv[5]), .injection_symbol_a(outv[6]), .injection_symbol_b(outv[7]),
        .receive_condition_a(outv[9]), .receive_condition_b(outv[10]), .receive_condition_mask_a(outv[11]),
        .receive_condition_mask_b(outv[12]), .noise_threshold(outv[13]), .noise_prescale_threshold(outv[14]),
        .state_threshold(outv[17]), .state_prescale_threshold(outv[18]), .link_error_threshold(outv[21]),
        .user_definable(outv[23]), .interrupt_condition_compare(outv[26]), .transmit_state_compare(outv[27]),
        .receive_condition_compare_a(outv[28]), .receive_condition_compare_b(outv[29]),
        .second_mode_control(outv[30]), .connection_mgmt_compare(outv[31]), .connection_mgmt_condition(outv[32]),
        .connection_mgmt_mask(outv[33]), .scrub_timer_threshold(outv[36]), .trigger_definition(outv[38]),
        .trigger_transition_config(outv[39]), .clock_generation_control(outv[59]),
        .alternate_media_control(outv[60]), .recovery_gain_control(outv[61])
    );

    // access class: 0 free, 1 gated, 2 live, 3 reserved
    function automatic int kind(input logic [5:0] a);
        case (a)
            6'h01, 6'h02, 6'h04, 6'h09, 6'h0a, 6'h1e, 6'h20: return 1;
            6'h08, 6'h0f, 6'h10, 6'h13, 6'h14, 6'h16, 6'h18, 6'h19, 6'h25: return 2;
            default: return host.rsvd(a) ? 3 : 0;
        endcase
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        checked++;
        if (seen !== want)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask

    // write with its permit; the model takes it only where it may land
    task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic en);
        host.req(1'b1, a, d);
        alw[a] <= en;
        notes.push_back('{a, 1'b0, 8'h00});
        if (kind(a) == 0 || (kind(a) == 1 && en))
            exp_q[a] = d;
    endtask

    task automatic rd(input logic [5:0] a);
        host.req(1'b0, a, 8'h00);
        notes.push_back('{a, kind(a) != 3, kind(a) == 2 ? (a == 6'h18 ? ID : live[a]) : exp_q[a]});
    endtask

    // hardware event bit held for one edge
    task automatic pulse(input logic [5:0] a, input logic [7:0] b);
        @(posedge ref_clk);
        setv[a] <= b;
        exp_q[a] = exp_q[a] | b;
        @(posedge ref_clk);
        setv[a] <= 8'h00;
    endtask

    // results come back in issue order, one ack each
    always @(posedge ref_clk)
    begin
        if (cb_ack === 1'b1)
        begin
            if (notes.size() == 0)
                check("spare ack", 8'h01, 8'h00);
            else
            begin
                note = notes.pop_front();
                if (note.chk)
                    check($sformatf("loc %h", note.a), cb_rdata, note.v);
            end
        end
    end

    task automatic give_verdict;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // run needs about 245 cycles; sixteen times that is a hang
    initial
    begin
        #160000;
        num_errors++;
        give_verdict();
    end

    initial
    begin
        for (int i = 0; i < 64; i++)
        begin
            live[i]  = $random(seed);
            setv[i]  = 8'h00;
            exp_q[i] = 8'h00;
        end
        exp_q[2]  = 8'h10;
        exp_q[4]  = 8'ha2;
        exp_q[9]  = 8'h20;
        exp_q[10] = 8'h02;
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge ref_clk);
        // every place read back to back, reset contents
        for (int i = 0; i < 64; i++)
            rd(i[5:0]);
        // writes with permits low, then read all
        for (int i = 0; i < 64; i++)
            if (!host.rsvd(i[5:0]))
                wr(i[5:0], $random(seed), 1'b0);
        for (int i = 0; i < 64; i++)
            rd(i[5:0]);
        // permit high lands, permit low refused, read next edge
        foreach (cl[i])
        begin
            wr(cl[i], $random(seed), 1'b1);
            rd(cl[i]);
            wr(cl[i], $random(seed), 1'b0);
            rd(cl[i]);
        end
        // event bits set into gated conditions
        foreach (el[i])
        begin
            host.idle();
            pulse(el[i], 8'h01 << i);
            rd(el[i]);
        end
        // event set wins over a same-cycle write of zero
        wr(6'h09, 8'h00, 1'b1);
        setv[9] <= 8'h04;
        exp_q[9] = 8'h04;
        host.idle();
        setv[9] <= 8'h00;
        rd(6'h09);
        // ce low freezes the bank, so this write is never taken nor acked
        host.idle();
        host.req(1'b1, 6'h17, ~exp_q[23]);
        ce <= 1'b0;
        host.idle();
        ce <= 1'b1;
        rd(6'h17);
        host.idle();
        repeat (4) @(posedge ref_clk);
        check("pending acks", 8'(notes.size()), 8'h00);
        // stored contents must also reach the device side
        for (int i = 0; i < 64; i++)
            if (kind(i[5:0]) < 2)
                check($sformatf("out %h", i[5:0]), outv[i], exp_q[i]);
        give_verdict();
    end
endmodule // phyreg_bank_tb

bind phyreg_bank phyreg_bank_props u_props (
    .ref_clk, .rst_b, .ce, .cb_sel, .cb_wr, .cb_addr, .cb_wdata, .cb_rdata, .cb_ack,
    .wr_allow_config, .rx_state_cur, .mode_control, .configuration_select, .recovery_gain_control
);
